// ### bench/cao_core_checker.sv
module cao_core_checker
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Fetch link and interrupt
  input wire logic        fetch_req,
  input wire logic [15:0] fetch_addr,
  input wire logic        fetch_valid,
  input wire logic [7:0]  fetch_data,
  input wire logic        irq_req,
  input wire logic        irq_ack,
  input wire logic        halted
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ---------------------------------------------------------------
  // Instruction steps
  // ---------------------------------------------------------------
  // One byte taken from memory
  sequence s_take;
    fetch_req && fetch_valid;
  endsequence
  // Three counted states with no new fetch
  sequence s_quiet3;
    !fetch_req [*3];
  endsequence

  a_state_count: assert property (s_take |=> s_quiet3)
    else $error("fetch came back before four states");
  a_pc_step: assert property (s_take |=> fetch_addr == $past(fetch_addr) + 16'h0001)
    else $error("program counter did not step by one");
  a_halt_enter: assert property ((s_take ##0 fetch_data == 8'h76) |=>
                                 s_quiet3 ##0 !halted ##1 halted)
    else $error("halt not entered on the fourth state");
  a_halt_quiet: assert property (halted |-> !fetch_req)
    else $error("fetch while halted");
  a_halt_hold: assert property (halted && !irq_req |=> halted)
    else $error("halt left without an interrupt");
  a_ack_wakes: assert property (irq_ack |-> !halted && !$past(irq_ack))
    else $error("acknowledge while still halted");
  a_fetch_stands: assert property (fetch_req && !fetch_valid |=> fetch_req && $stable(fetch_addr))
    else $error("fetch request dropped before taken");
  a_apb_wait: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer not one wait state");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside the answer cycle");
  a_err_with: assert property (pslverr |-> pready)
    else $error("error without ready");
  c_irq_ack: cover property (irq_ack);
endmodule // cao_core_checker

bind cao_core cao_core_checker i_cao_core_checker
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_valid(fetch_valid),
  .fetch_data(fetch_data), .irq_req(irq_req), .irq_ack(irq_ack), .halted(halted)
);

// ### bench/cao_prog_mem.sv
module cao_prog_mem
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Extra wait cycles before each byte
  input  wire logic [1:0]  slow,
  // Fetch link
  input  wire logic        fetch_req,
  input  wire logic [15:0] fetch_addr,
  output logic             fetch_valid,
  output logic      [7:0]  fetch_data
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem [256];
  logic [1:0] wait_q;
  logic [7:0] last_q;

  // Answer at once or after slow cycles; idle data is the inverse of the last byte
  assign fetch_valid = fetch_req && (wait_q >= slow);
  assign fetch_data  = fetch_valid ? mem[fetch_addr[7:0]] : ~last_q;

  // Wait counter restarts after every byte handed over
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wait_q <= 2'h0;
      last_q <= 8'h00;
    end
    else if (fetch_valid)
    begin
      wait_q <= 2'h0;
      last_q <= fetch_data;
    end
    else if (fetch_req)
      wait_q <= wait_q + 2'h1;
  end
endmodule // cao_prog_mem

// ### bench/cpu_control_and_acc_ops_tb.sv
`include "cao_params.svh"

module cpu_control_and_acc_ops_tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [31:0] prog;
    logic [2:0]  nb;
    logic [7:0]  acc_i;
    logic [7:0]  fl_i;
    logic [7:0]  acc_x;
    logic [7:0]  fl_x;
    logic [7:0]  fl_m;
    logic [3:0]  st_x;
  } cao_case_t;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        fetch_req, fetch_valid, irq_req, irq_ack, halted, err, seen;
  logic [15:0] fetch_addr;
  logic [7:0]  fetch_data;
  logic [1:0]  slow;
  int          fails, cmp_count;
  cao_case_t   cases [15];
  cao_case_t   c;

  cao_core i_cao_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fetch_valid(fetch_valid), .fetch_data(fetch_data), .irq_req(irq_req),
    .irq_ack(irq_ack), .halted(halted));
  cao_prog_mem i_cao_prog_mem (.pclk(pclk), .presetn(presetn), .slow(slow),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_valid(fetch_valid),
    .fetch_data(fetch_data));

  // ---------------------------------------------------------------
  // Clock, watchdog and verdict
  // ---------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // About 65 cycles per case; the limit leaves plenty of margin
  initial
  begin
    #100000;
    fails++;
    tally_and_finish();
  end

  task automatic tally_and_finish();
    $display("Counts: compares=%0d mismatches=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, got, exp);
    end
  endtask

  // ---------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------
  // Request held until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task automatic wait_halt();
    int n;
    n = 0;
    while (halted !== 1'b1 && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
  endtask

  // ---------------------------------------------------------------
  // Cases: program, byte count, acc in, flags in, acc out, flags out, mask, status
  // ---------------------------------------------------------------
  initial
  begin
    cases[0]  = '{32'h2700_0000, 3'd1, 8'h9A, 8'h00, 8'h00, 8'h55, 8'hD7, 4'h1};
    cases[1]  = '{32'h2700_0000, 3'd1, 8'h2F, 8'h12, 8'h29, 8'h02, 8'hD7, 4'h1};
    cases[2]  = '{32'h2F00_0000, 3'd1, 8'h5A, 8'hC1, 8'hA5, 8'hD3, 8'hD3, 4'h1};
    cases[3]  = '{32'hED44_0000, 3'd2, 8'h80, 8'h00, 8'h80, 8'h87, 8'hD7, 4'h1};
    cases[4]  = '{32'hED44_0000, 3'd2, 8'h01, 8'h40, 8'hFF, 8'h93, 8'hD7, 4'h1};
    cases[5]  = '{32'h3F00_0000, 3'd1, 8'h11, 8'hC5, 8'h11, 8'hC4, 8'hC7, 4'h1};
    cases[6]  = '{32'h3F00_0000, 3'd1, 8'h11, 8'h02, 8'h11, 8'h01, 8'hC7, 4'h1};
    cases[7]  = '{32'h3700_0000, 3'd1, 8'h22, 8'h12, 8'h22, 8'h01, 8'hD7, 4'h1};
    cases[8]  = '{32'h3700_0000, 3'd1, 8'h22, 8'hC4, 8'h22, 8'hC5, 8'hD7, 4'h1};
    cases[9]  = '{32'h0000_0000, 3'd1, 8'h33, 8'hD7, 8'h33, 8'hD7, 8'hD7, 4'h1};
    cases[10] = '{32'hFB00_0000, 3'd1, 8'h33, 8'h00, 8'h33, 8'h00, 8'hD7, 4'h3};
    cases[11] = '{32'hFBF3_0000, 3'd2, 8'h33, 8'hD7, 8'h33, 8'hD7, 8'hD7, 4'h1};
    cases[12] = '{32'hED56_0000, 3'd2, 8'h44, 8'h00, 8'h44, 8'h00, 8'hD7, 4'h5};
    cases[13] = '{32'hED5E_0000, 3'd2, 8'h44, 8'hD7, 8'h44, 8'hD7, 8'hD7, 4'h9};
    cases[14] = '{32'hED5E_ED46, 3'd4, 8'h44, 8'h00, 8'h44, 8'h00, 8'hD7, 4'h1};
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
    irq_req = 1'b0;
    slow    = 2'h0;
    fails   = 0;
    cmp_count = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 15; i++)
    begin
      c = cases[i];
      slow <= 2'(i % 3);
      do_reset();
      // Fill with halt bytes so a woken core stops again
      for (int k = 0; k < 256; k++)
        i_cao_prog_mem.mem[k] = 8'h76;
      for (int k = 0; k < 32'(c.nb); k++)
        i_cao_prog_mem.mem[k] = c.prog[31 - 8 * k -: 8];
      apb(1'b1, `CAO_OFF_ACC, {24'h0, c.acc_i});
      apb(1'b1, `CAO_OFF_FLAGS, {24'h0, c.fl_i});
      apb(1'b1, `CAO_OFF_CTRL, 32'h0000_0001);
      wait_halt();
      check({31'h0, halted}, 32'h0000_0001);
      apb(1'b0, `CAO_OFF_ACC, 32'h0);
      check(rd, {24'h0, c.acc_x});
      apb(1'b0, `CAO_OFF_FLAGS, 32'h0);
      check(rd & {24'h0, c.fl_m}, {24'h0, c.fl_x & c.fl_m});
      apb(1'b0, `CAO_OFF_PC, 32'h0);
      check(rd, 32'(c.nb) + 32'h1);
      apb(1'b0, `CAO_OFF_STATUS, 32'h0);
      check(rd & 32'h0000_000F, {28'h0, c.st_x});
      // Interrupt wakes the core only when the enable flip-flop is set
      seen = 1'b0;
      @(posedge pclk);
      irq_req <= 1'b1;
      repeat (8)
      begin
        @(posedge pclk);
        if (irq_ack === 1'b1)
          seen = 1'b1;
      end
      irq_req <= 1'b0;
      check({31'h0, seen}, {31'h0, c.st_x[1]});
      // A woken core meets the next halt byte and stops again within the 8 cycles
      check({31'h0, halted}, 32'h0000_0001);
    end
    // Unmapped place: write dropped, read gives zero with an error
    apb(1'b1, 12'h0FC, 32'hFFFF_FFFF);
    check({31'h0, err}, 32'h0000_0001);
    apb(1'b0, 12'h0FC, 32'h0);
    check({rd[30:0], err}, 32'h0000_0001);
    tally_and_finish();
  end
endmodule // cpu_control_and_acc_ops_tb

// ### rtl/cao_alu.sv
`include "cao_params.svh"

module cao_alu
(
  // Operands
  input  wire logic [7:0]           acc_i,
  input  wire logic [7:0]           flags_i,
  input  wire cao_pkg::cao_alu_op_t op_i,
  // Results
  output logic      [7:0]           acc_o,
  output logic      [7:0]           flags_o
);

  // Even parity gives 1
  function automatic logic even_par(input logic [7:0] v);
    even_par = ~(^v);
  endfunction

  logic [7:0] corr;
  logic       cin;
  logic       hin;
  logic       nin;

  assign cin = flags_i[`CAO_FLG_C];
  assign hin = flags_i[`CAO_FLG_H];
  assign nin = flags_i[`CAO_FLG_N];

  // Correction term for decimal adjust
  always_comb
  begin
    corr = 8'h00;
    if (hin || (acc_i[3:0] > 4'h9))
      corr[3:0] = 4'h6;
    if (cin || (acc_i > 8'h99))
      corr[7:4] = 4'h6;
  end

  // Result and flags; untouched flags pass straight through
  always_comb
  begin
    acc_o   = acc_i;
    flags_o = flags_i;
    unique case (op_i)
      cao_pkg::ALU_DAA:
      begin
        acc_o = nin ? (acc_i - corr) : (acc_i + corr);
        flags_o[`CAO_FLG_C]  = cin || (acc_i > 8'h99);
        flags_o[`CAO_FLG_H]  = nin ? (hin && (acc_i[3:0] < 4'h6))
                                   : (acc_i[3:0] > 4'h9);
        flags_o[`CAO_FLG_Z]  = (acc_o == 8'h00);
        flags_o[`CAO_FLG_S]  = acc_o[7];
        flags_o[`CAO_FLG_PV] = even_par(acc_o);
      end
      cao_pkg::ALU_CPL:
      begin
        acc_o = ~acc_i;
        flags_o[`CAO_FLG_N] = 1'b1;
        flags_o[`CAO_FLG_H] = 1'b1;
      end
      cao_pkg::ALU_NEG:
      begin
        acc_o = 8'h00 - acc_i;
        flags_o[`CAO_FLG_N]  = 1'b1;
        flags_o[`CAO_FLG_C]  = (acc_i != 8'h00);
        flags_o[`CAO_FLG_H]  = (acc_i[3:0] != 4'h0);
        flags_o[`CAO_FLG_Z]  = (acc_i == 8'h00);
        flags_o[`CAO_FLG_S]  = acc_o[7];
        flags_o[`CAO_FLG_PV] = (acc_i == 8'h80);
      end
      cao_pkg::ALU_CCF:
      begin
        flags_o[`CAO_FLG_C] = ~cin;
        flags_o[`CAO_FLG_N] = 1'b0;
        flags_o[`CAO_FLG_H] = cin;     // Unknown; old carry is the cheapest
      end
      cao_pkg::ALU_SCF:
      begin
        flags_o[`CAO_FLG_C] = 1'b1;
        flags_o[`CAO_FLG_N] = 1'b0;
        flags_o[`CAO_FLG_H] = 1'b0;
      end
      default:
      begin
        acc_o   = acc_i;
        flags_o = flags_i;
      end
    endcase
  end

endmodule // cao_alu

// ### rtl/cao_core.sv
// How it works
// - Decimal adjust (1 byte, 4 states) makes BCD, sets C, Z, S, H and parity, keeps N.
// - One's complement (1 byte, 4 states) inverts the acc, sets N and H, keeps Z and S.
// - Negate (2 bytes, 8 states) gives the two's complement, sets N, overflow and results.
// - Invert carry (1 byte, 4 states) flips C, clears N, leaves H unknown (here H takes the old C), keeps Z, S, P/V.
// - The all-zero idle instruction only advances the program counter, in 4 states.
// - Halt (1 byte, 4 states) enters the halted condition and alters no flag.
// - The disable instruction clears and the enable one sets the interrupt enable, 4 states.
// - Three prefixed 8-state instructions select interrupt mode 0, 1 or 2, which persists.
// - Parity on P/V is 1 for an even count of one bits and 0 for odd.
// - Overflow on P/V is 1 when a signed overflow occurred and 0 otherwise.
// - Unaffected flags keep their value, reset flags are 0, set flags are 1.
`include "cao_params.svh"

module cao_core
(
  // APB clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Program memory fetch
  output logic             fetch_req,
  output logic      [15:0] fetch_addr,
  input  wire logic        fetch_valid,
  input  wire logic [7:0]  fetch_data,
  // Interrupt request and acknowledge
  input  wire logic        irq_req,
  output logic             irq_ack,
  output logic             halted
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  cao_pkg::cao_seq_t    seq_q;
  cao_pkg::cao_imode_t  imode_q;
  cao_pkg::cao_alu_op_t alu_op;
  logic [1:0]  tcnt_q;
  logic [7:0]  byte_q;
  logic        prefix_q;
  logic [15:0] pc_q;
  logic [7:0]  acc_q;
  logic [7:0]  flags_q;
  logic        run_q;
  logic        iff_q;
  logic        halt_q;
  logic        fetch_req_q;
  logic        irq_ack_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [7:0]  acc_n;
  logic [7:0]  flags_n;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  logic apb_acc;
  logic apb_wr;
  logic hit;

  // Access taken on the first cycle of the access phase
  assign apb_acc = psel && penable && !pready_q;
  assign apb_wr  = apb_acc && pwrite;

  always_comb
  begin
    unique case (paddr)
      `CAO_OFF_CTRL, `CAO_OFF_ACC, `CAO_OFF_FLAGS,
      `CAO_OFF_STATUS, `CAO_OFF_PC: hit = 1'b1;
      default:                      hit = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Instruction decode
  // ---------------------------------------------------------------
  logic last_state;
  logic exec;
  logic is_prefix;
  logic is_halt;
  logic is_di;
  logic is_ei;
  logic is_im;
  cao_pkg::cao_imode_t im_val;

  assign last_state = (seq_q == cao_pkg::SEQ_WAIT) && (tcnt_q == `CAO_STATES_PER_M);
  assign is_prefix  = !prefix_q && (byte_q == `CAO_OP_PREFIX);
  // Execution lands on the last state of the final machine cycle
  assign exec       = last_state && !is_prefix;

  // Unknown opcodes fall into the idle case and change nothing
  always_comb
  begin
    alu_op  = cao_pkg::ALU_NONE;
    is_halt = 1'b0;
    is_di   = 1'b0;
    is_ei   = 1'b0;
    is_im   = 1'b0;
    im_val  = cao_pkg::IMODE_0;
    if (prefix_q)
    begin
      unique case (byte_q)
        `CAO_OP_NEG: alu_op = cao_pkg::ALU_NEG;
        `CAO_OP_IM0: is_im  = 1'b1;
        `CAO_OP_IM1:
        begin
          is_im  = 1'b1;
          im_val = cao_pkg::IMODE_1;
        end
        `CAO_OP_IM2:
        begin
          is_im  = 1'b1;
          im_val = cao_pkg::IMODE_2;
        end
        default:     alu_op = cao_pkg::ALU_NONE;
      endcase
    end
    else
    begin
      unique case (byte_q)
        `CAO_OP_DAA:  alu_op  = cao_pkg::ALU_DAA;
        `CAO_OP_CPL:  alu_op  = cao_pkg::ALU_CPL;
        `CAO_OP_CCF:  alu_op  = cao_pkg::ALU_CCF;
        `CAO_OP_SCF:  alu_op  = cao_pkg::ALU_SCF;
        `CAO_OP_HALT: is_halt = 1'b1;
        `CAO_OP_DI:   is_di   = 1'b1;
        `CAO_OP_EI:   is_ei   = 1'b1;
        `CAO_OP_NOP:  alu_op  = cao_pkg::ALU_NONE;
        default:      alu_op  = cao_pkg::ALU_NONE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Arithmetic unit
  // ---------------------------------------------------------------
  cao_alu u_alu
  (
    .acc_i   (acc_q),
    .flags_i (flags_q),
    .op_i    (alu_op),
    .acc_o   (acc_n),
    .flags_o (flags_n)
  );

  // ---------------------------------------------------------------
  // Sequencer: fetch, count states, execute
  // ---------------------------------------------------------------
  logic take_irq;

  assign take_irq = (seq_q == cao_pkg::SEQ_HALT) && irq_req && iff_q;

  // Program counter moves only when a byte is taken or a bus write loads it in stop, never in halt
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seq_q       <= cao_pkg::SEQ_STOP;
      tcnt_q      <= 2'd0;
      byte_q      <= `CAO_OP_NOP;
      prefix_q    <= 1'b0;
      pc_q        <= `CAO_RST_PC;
      fetch_req_q <= 1'b0;
    end
    else
    begin
      unique case (seq_q)
        cao_pkg::SEQ_STOP:
        begin
          if (apb_wr && paddr == `CAO_OFF_PC)
            pc_q <= pwdata[15:0];
          if (run_q)
          begin
            seq_q       <= cao_pkg::SEQ_FETCH;
            fetch_req_q <= 1'b1;
          end
        end
        cao_pkg::SEQ_FETCH:
        begin
          if (fetch_valid)
          begin
            byte_q      <= fetch_data;
            pc_q        <= pc_q + 16'h0001;
            fetch_req_q <= 1'b0;
            tcnt_q      <= 2'd1;
            seq_q       <= cao_pkg::SEQ_WAIT;
          end
        end
        cao_pkg::SEQ_WAIT:
        begin
          tcnt_q <= tcnt_q + 2'd1;
          if (last_state)
          begin
            tcnt_q   <= 2'd0;
            prefix_q <= is_prefix;                   // Second byte adds 4 states
            if (exec && is_halt)
              seq_q <= cao_pkg::SEQ_HALT;
            else if (run_q || is_prefix)
            begin
              seq_q       <= cao_pkg::SEQ_FETCH;
              fetch_req_q <= 1'b1;
            end
            else
              seq_q <= cao_pkg::SEQ_STOP;
          end
        end
        cao_pkg::SEQ_HALT:
        begin
          // Internal idle machine cycles; program flow frozen
          tcnt_q <= tcnt_q + 2'd1;
          if (take_irq)
          begin
            tcnt_q      <= 2'd0;
            seq_q       <= cao_pkg::SEQ_FETCH;
            fetch_req_q <= 1'b1;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Accumulator and flags; execution beats a same-cycle bus write
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_q   <= `CAO_RST_ACC;
      flags_q <= `CAO_RST_FLAGS;
    end
    else if (exec)
    begin
      acc_q   <= acc_n;
      flags_q <= flags_n;
    end
    else if (apb_wr && paddr == `CAO_OFF_ACC)
      acc_q <= pwdata[7:0];
    else if (apb_wr && paddr == `CAO_OFF_FLAGS)
      flags_q <= pwdata[7:0];
  end

  // ---------------------------------------------------------------
  // CPU control: run, interrupt enable, mode, halt, acknowledge
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_q     <= 1'b0;
      iff_q     <= 1'b0;
      imode_q   <= cao_pkg::IMODE_0;
      halt_q    <= 1'b0;
      irq_ack_q <= 1'b0;
    end
    else
    begin
      irq_ack_q <= take_irq;
      if (apb_wr && paddr == `CAO_OFF_CTRL)
        run_q <= pwdata[`CAO_CTRL_RUN];
      if (exec && is_di)
        iff_q <= 1'b0;
      else if (exec && is_ei)
        iff_q <= 1'b1;
      else if (take_irq)
        iff_q <= 1'b0;              // Masks nested requests on acceptance
      if (exec && is_im)
        imode_q <= im_val;
      if (exec && is_halt)
        halt_q <= 1'b1;
      else if (take_irq)
        halt_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // APB response: one wait state, registered data and error
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q  <= apb_acc;
      pslverr_q <= apb_acc && !hit;
      prdata_q  <= 32'h0000_0000;
      if (apb_acc && !pwrite)
      begin
        unique case (paddr)
          `CAO_OFF_CTRL:   prdata_q <= {31'h0, run_q};
          `CAO_OFF_ACC:    prdata_q <= {24'h0, acc_q};
          `CAO_OFF_FLAGS:  prdata_q <= {24'h0, flags_q};
          `CAO_OFF_STATUS: prdata_q <= {27'h0, (seq_q != cao_pkg::SEQ_STOP),
                                        imode_q, iff_q, halt_q};
          `CAO_OFF_PC:     prdata_q <= {16'h0, pc_q};
          default:         prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign fetch_req  = fetch_req_q;
  assign fetch_addr = pc_q;
  assign irq_ack    = irq_ack_q;
  assign halted     = halt_q;

endmodule // cao_core

// ### rtl/cao_params.svh
`ifndef CAO_PARAMS_SVH
`define CAO_PARAMS_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses on APB)
// ---------------------------------------------------------------
`define CAO_OFF_CTRL    12'h000
`define CAO_OFF_ACC     12'h004
`define CAO_OFF_FLAGS   12'h008
`define CAO_OFF_STATUS  12'h00C
`define CAO_OFF_PC      12'h010

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CAO_CTRL_RUN    0
`define CAO_FLG_C       0
`define CAO_FLG_N       1
`define CAO_FLG_PV      2
`define CAO_FLG_H       4
`define CAO_FLG_Z       6
`define CAO_FLG_S       7
`define CAO_ST_HALT     0
`define CAO_ST_IFF      1
`define CAO_ST_MODE_LO  2
`define CAO_ST_MODE_HI  3
`define CAO_ST_BUSY     4

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define CAO_RST_ACC     8'h00
`define CAO_RST_FLAGS   8'h00
`define CAO_RST_PC      16'h0000

// ---------------------------------------------------------------
// Opcode bytes
// ---------------------------------------------------------------
`define CAO_OP_NOP      8'h00
`define CAO_OP_DAA      8'h27
`define CAO_OP_CPL      8'h2F
`define CAO_OP_SCF      8'h37
`define CAO_OP_CCF      8'h3F
`define CAO_OP_HALT     8'h76
`define CAO_OP_DI       8'hF3
`define CAO_OP_EI       8'hFB
`define CAO_OP_PREFIX   8'hED
`define CAO_OP_NEG      8'h44
`define CAO_OP_IM0      8'h46
`define CAO_OP_IM1      8'h56
`define CAO_OP_IM2      8'h5E

// ---------------------------------------------------------------
// Timing: last counted state of a machine cycle after its fetch state, one state per pclk
// ---------------------------------------------------------------
`define CAO_STATES_PER_M 2'd3

`endif

// ### rtl/cao_pkg.sv
package cao_pkg;

  // Accumulator and flag operations of the arithmetic unit
  typedef enum logic [2:0] {
    ALU_NONE = 3'b000,
    ALU_DAA  = 3'b001,
    ALU_CPL  = 3'b010,
    ALU_NEG  = 3'b011,
    ALU_CCF  = 3'b100,
    ALU_SCF  = 3'b101
  } cao_alu_op_t;

  // Instruction sequencer states
  typedef enum logic [1:0] {
    SEQ_STOP  = 2'b00,
    SEQ_FETCH = 2'b01,
    SEQ_WAIT  = 2'b10,
    SEQ_HALT  = 2'b11
  } cao_seq_t;

  // Interrupt response mode
  typedef enum logic [1:0] {
    IMODE_0 = 2'b00,
    IMODE_1 = 2'b01,
    IMODE_2 = 2'b10
  } cao_imode_t;

endpackage
